/* File: logic/power_mode_wakeup_irq_ctrl.v */
// Power mode sequencer, wakeup control and interrupt flag registers.
// Assumes a classic Wishbone master on clk, a core that takes
// irq_take as a branch request and pulses return_from_interrupt.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/100ps
`include "pwr_defs.vh"

// Function
// - cpu_mode selects normal, sleep, green; 11 reserved
// - slow_clock_select picks high or low clock
// - high_osc_stop halts high oscillator only, in slow or green mode
// - Slow mode instruction rate is low clock/4
// - Oscillator enables follow mode table
// - No execution in sleep or green
// - Timer zero runs except sleep, when enabled
// - Second timer runs normal/slow, when enabled
// - USB runs only normal mode, when enabled
// - Interrupt sources gated per mode
// - Sleep exits only by pin or reset
// - Sleep wake sources: port change, USB toggle
// - Green wake returns to previous mode
// - Without timer zero, green wakes by pins
// - Sleep wake waits 2048 periods plus startup
// - Green wake resumes with no delay
// - Service clears global enable; return sets it
// - Taken interrupt pushes stack, vector 8
// - Enable register holds seven enable bits
// - Request flags share enable bit positions
// - Flags stick until software writes them
// - External pin event wakes sleep to normal mode
module power_mode_wakeup_irq_ctrl #(
  parameter PORT_W        = 16,
  parameter WAKE_CYCLES   = (`WAKE_PERIODS * `SYS_CLK_MHZ + `HIGH_OSC_MHZ - 1) / `HIGH_OSC_MHZ,
  parameter STARTUP_CYCLES = 16
) (
  // Clock and reset
  input  wire              clk,
  input  wire              rst_n,
  // Wishbone slave
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [11:0]       wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output reg  [31:0]       wb_dat_o,
  output reg               wb_ack_o,
  // Pins from outside the clock domain
  input  wire [PORT_W-1:0] port_pins,
  input  wire              usb_bus_toggle,
  input  wire              low_osc_clk,
  // Events from logic on clk
  input  wire              timer_zero_overflow,
  input  wire              second_timer_overflow,
  input  wire              serial_done,
  input  wire              usb_done,
  input  wire              return_from_interrupt,
  // Clock and function gating
  output reg               high_osc_run,
  output reg               low_osc_run,
  output reg               sys_clk_low,
  output reg               cpu_run,
  output reg               instr_tick,
  output reg               timer_zero_active,
  output reg               second_timer_active,
  output reg               usb_active,
  // Interrupt request to the core
  output reg               irq_take,
  output reg  [3:0]        irq_vector
);

  localparam ST_RUN    = 2'h0;
  localparam ST_SLEEP  = 2'h1;
  localparam ST_SETTLE = 2'h2;
  localparam ST_GREEN  = 2'h3;
  localparam SETTLE_TOTAL = WAKE_CYCLES + STARTUP_CYCLES;

  // ******************************************************
  // Input synchronisers
  // ******************************************************
  reg [PORT_W-1:0] port_s1;
  reg [PORT_W-1:0] port_s2;
  reg [PORT_W-1:0] port_s3;
  reg [2:0]        usb_s;
  reg [2:0]        lowc_s;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_s1 <= {PORT_W{1'b0}};
      port_s2 <= {PORT_W{1'b0}};
      port_s3 <= {PORT_W{1'b0}};
      usb_s   <= 3'h0;
      lowc_s  <= 3'h0;
    end else begin
      port_s1 <= port_pins;
      port_s2 <= port_s1;
      port_s3 <= port_s2;
      usb_s   <= {usb_s[1:0], usb_bus_toggle};
      lowc_s  <= {lowc_s[1:0], low_osc_clk};
    end
  end

  wire port_change = |(port_s2 ^ port_s3);
  wire ext0_change = port_s2[0] ^ port_s3[0];
  wire ext1_change = port_s2[1] ^ port_s3[1];
  wire usb_change  = usb_s[2] ^ usb_s[1];
  wire low_rise    = lowc_s[1] & ~lowc_s[2];

  // ******************************************************
  // Registers
  // ******************************************************
  reg [1:0]  cpu_mode;
  reg        slow_clock_select;
  reg        high_osc_stop;
  reg [6:0]  irq_request_flags;
  reg [6:0]  irq_enable_mask;
  reg        global_irq_enable;
  reg [2:0]  stack_pointer_reg;
  reg        timer_zero_run_enable;
  reg        second_timer_run_enable;
  reg        usb_function_enable;
  reg [1:0]  state;
  reg [15:0] settle_cnt;
  reg [1:0]  slow_cnt;

  wire       bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       adr_ok   = (wb_adr_i[11:10] == 2'h0) & (wb_adr_i[1:0] == 2'h0);
  wire [7:0] idx      = wb_adr_i[9:2];
  wire       wr_lane  = bus_req & wb_we_i & wb_sel_i[0] & adr_ok;
  wire       wr_flags = wr_lane & (idx == `IDX_IRQ_FLAGS);
  wire       wr_en    = wr_lane & (idx == `IDX_IRQ_ENABLE);
  wire       wr_osc   = wr_lane & (idx == `IDX_OSC_CTRL);
  wire       wr_stack = wr_lane & (idx == `IDX_STACK);
  wire       wr_run   = wr_lane & (idx == `IDX_RUN_ENABLE);

  wire executing = (state == ST_RUN);
  wire in_green  = (state == ST_GREEN);
  wire asleep    = (state == ST_SLEEP) | (state == ST_SETTLE);

  // ******************************************************
  // Interrupt event gating
  // ******************************************************
  reg [6:0] set_events;

  always @* begin
    set_events = 7'h00;
    if (!asleep) begin
      set_events[`IRQ_EXT0] = ext0_change;
      set_events[`IRQ_EXT1] = ext1_change;
      set_events[`IRQ_WAKE] = port_change;
      set_events[`IRQ_T0]   = timer_zero_overflow & timer_zero_run_enable;
      if (!in_green) begin
        set_events[`IRQ_SERIAL] = serial_done;
        set_events[`IRQ_TC0]    = second_timer_overflow;
        set_events[`IRQ_USB]    = usb_done;
      end
    end
  end

  wire pending = |(irq_request_flags & irq_enable_mask);
  wire take    = executing & global_irq_enable & pending & ~irq_take;

  // ******************************************************
  // Wakeup sources
  // ******************************************************
  wire sleep_wake = port_change | usb_change;
  wire t0_wake    = timer_zero_overflow & timer_zero_run_enable;
  wire green_wake = port_change | usb_change | t0_wake;

  // ******************************************************
  // Mode state machine
  // ******************************************************
  reg [1:0]  next_state;
  reg [15:0] next_settle_cnt;
  reg        wake_clear;

  always @* begin
    next_state      = state;
    next_settle_cnt = settle_cnt;
    wake_clear      = 1'b0;
    case (state)
      ST_RUN: begin
        if (cpu_mode == `MODE_SLEEP) begin
          next_state = ST_SLEEP;
        end else if (cpu_mode == `MODE_GREEN) begin
          next_state = ST_GREEN;
        end
      end
      ST_SLEEP: begin
        if (sleep_wake) begin
          next_state      = ST_SETTLE;
          next_settle_cnt = SETTLE_TOTAL[15:0];
        end
      end
      ST_SETTLE: begin
        if (settle_cnt <= 16'h0001) begin
          next_state = ST_RUN;
          wake_clear = 1'b1;
        end else begin
          next_settle_cnt = settle_cnt - 16'h0001;
        end
      end
      ST_GREEN: begin
        if (green_wake) begin
          next_state = ST_RUN;
          wake_clear = 1'b1;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // ******************************************************
  // Register writes and hardware updates
  // ******************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state                   <= ST_RUN;
      settle_cnt              <= 16'h0000;
      cpu_mode                <= `MODE_NORMAL;
      slow_clock_select       <= 1'b0;
      high_osc_stop           <= 1'b0;
      irq_request_flags       <= `IRQ_RESET;
      irq_enable_mask         <= `IRQ_RESET;
      global_irq_enable       <= 1'b0;
      stack_pointer_reg       <= `STACK_RESET;
      timer_zero_run_enable   <= 1'b0;
      second_timer_run_enable <= 1'b0;
      usb_function_enable     <= 1'b0;
    end else begin
      state      <= next_state;
      settle_cnt <= next_settle_cnt;
      if (wake_clear) begin
        cpu_mode <= `MODE_NORMAL;
        if (state == ST_SETTLE) begin
          slow_clock_select <= 1'b0;
          high_osc_stop     <= 1'b0;
        end
      end else if (wr_osc) begin
        cpu_mode          <= {wb_dat_i[`BIT_MODE_HIGH], wb_dat_i[`BIT_MODE_LOW]};
        slow_clock_select <= wb_dat_i[`BIT_SLOW_CLK_SEL];
        high_osc_stop     <= wb_dat_i[`BIT_HIGH_OSC_STOP];
      end
      if (wr_flags) begin
        irq_request_flags <= wb_dat_i[6:0] | set_events;
      end else begin
        irq_request_flags <= irq_request_flags | set_events;
      end
      if (wr_en) begin
        irq_enable_mask <= wb_dat_i[6:0];
      end
      if (take) begin
        global_irq_enable <= 1'b0;
        stack_pointer_reg <= stack_pointer_reg + 3'h1;
      end else if (return_from_interrupt) begin
        global_irq_enable <= 1'b1;
        stack_pointer_reg <= stack_pointer_reg - 3'h1;
      end else if (wr_stack) begin
        global_irq_enable <= wb_dat_i[`BIT_GIE];
        stack_pointer_reg <= wb_dat_i[2:0];
      end
      if (wr_run) begin
        timer_zero_run_enable   <= wb_dat_i[`BIT_T0_RUN];
        second_timer_run_enable <= wb_dat_i[`BIT_TC0_RUN];
        usb_function_enable     <= wb_dat_i[`BIT_USB_RUN];
      end
    end
  end

  // ******************************************************
  // Wishbone answer
  // ******************************************************
  reg [31:0] next_dat;

  always @* begin
    next_dat = 32'h00000000;
    if (adr_ok) begin
      case (idx)
        `IDX_IRQ_FLAGS:  next_dat[6:0] = irq_request_flags;
        `IDX_IRQ_ENABLE: next_dat[6:0] = irq_enable_mask;
        `IDX_OSC_CTRL: begin
          next_dat[`BIT_MODE_HIGH]     = cpu_mode[1];
          next_dat[`BIT_MODE_LOW]      = cpu_mode[0];
          next_dat[`BIT_SLOW_CLK_SEL]  = slow_clock_select;
          next_dat[`BIT_HIGH_OSC_STOP] = high_osc_stop;
        end
        `IDX_STACK: begin
          next_dat[`BIT_GIE] = global_irq_enable;
          next_dat[2:0]      = stack_pointer_reg;
        end
        `IDX_RUN_ENABLE: begin
          next_dat[`BIT_T0_RUN]  = timer_zero_run_enable;
          next_dat[`BIT_TC0_RUN] = second_timer_run_enable;
          next_dat[`BIT_USB_RUN] = usb_function_enable;
        end
        `IDX_STATUS: begin
          next_dat[1:0] = state;
          next_dat[2]   = high_osc_run;
          next_dat[3]   = low_osc_run;
          next_dat[4]   = cpu_run;
        end
        default: next_dat = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= next_dat;
      end
    end
  end

  // ******************************************************
  // Gating outputs
  // ******************************************************
  wire slow_mode = slow_clock_select;
  wire normal_run = executing & ~slow_mode;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_osc_run        <= 1'b1;
      low_osc_run         <= 1'b1;
      sys_clk_low         <= 1'b0;
      cpu_run             <= 1'b1;
      instr_tick          <= 1'b0;
      timer_zero_active   <= 1'b0;
      second_timer_active <= 1'b0;
      usb_active          <= 1'b0;
      irq_take            <= 1'b0;
      irq_vector          <= 4'h0;
      slow_cnt            <= 2'h0;
    end else begin
      high_osc_run <= (normal_run | (~asleep & ~high_osc_stop))
                      | (state == ST_SETTLE);
      low_osc_run  <= ~asleep;
      sys_clk_low  <= slow_mode & ~asleep;
      cpu_run      <= executing;
      if (executing && slow_mode && low_rise) begin
        slow_cnt <= slow_cnt + 2'h1;
      end
      instr_tick <= executing & (~slow_mode |
                    (low_rise & (slow_cnt == (`SLOW_DIV - 1))));
      timer_zero_active   <= timer_zero_run_enable & ~asleep;
      second_timer_active <= second_timer_run_enable & executing;
      usb_active          <= usb_function_enable & normal_run;
      irq_take            <= take;
      if (take) begin
        irq_vector <= `IRQ_VECTOR;
      end
    end
  end

endmodule

/* File: logic/pwr_defs.vh */
// Register indices, field positions, reset values and timing figures
// for the power mode, wakeup and interrupt controller.
// Assumes inclusion by bare name from the design file.
`ifndef PWR_DEFS_VH
`define PWR_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_IRQ_FLAGS   8'hC8
`define IDX_IRQ_ENABLE  8'hC9
`define IDX_OSC_CTRL    8'hCA
`define IDX_STACK       8'hDF
`define IDX_RUN_ENABLE  8'hE0
`define IDX_STATUS      8'hE1

// Oscillator control fields
`define BIT_HIGH_OSC_STOP  1
`define BIT_SLOW_CLK_SEL   2
`define BIT_MODE_LOW       3
`define BIT_MODE_HIGH      4

// Stack register fields
`define BIT_GIE            7
`define STACK_RESET        3'h7

// Run enable fields
`define BIT_T0_RUN         0
`define BIT_TC0_RUN        1
`define BIT_USB_RUN        2

// Interrupt bit positions
`define IRQ_EXT0           0
`define IRQ_EXT1           1
`define IRQ_WAKE           2
`define IRQ_SERIAL         3
`define IRQ_T0             4
`define IRQ_TC0            5
`define IRQ_USB            6
`define IRQ_RESET          7'h00

// Mode codes
`define MODE_NORMAL        2'h0
`define MODE_SLEEP         2'h1
`define MODE_GREEN         2'h2

// Interrupt vector
`define IRQ_VECTOR         4'h8

// Timing
`define WAKE_PERIODS       2048
`define SYS_CLK_MHZ        40
`define HIGH_OSC_MHZ       6
`define SLOW_DIV           4

`endif

/* File: tb/pwr_checker_assertions.sv */
// Port checker for the power mode, wakeup and interrupt controller.
// Assumes it is bound onto the controller's top module.
`timescale 1ns/100ps
module pwr_checker (
  // Clock and reset
  input logic       clk,
  input logic       rst_n,
  // Bus
  input logic       wb_cyc_i,
  input logic       wb_stb_i,
  input logic       wb_ack_o,
  // Gating and interrupt outputs
  input logic       high_osc_run,
  input logic       low_osc_run,
  input logic       sys_clk_low,
  input logic       cpu_run,
  input logic       instr_tick,
  input logic       timer_zero_active,
  input logic       second_timer_active,
  input logic       usb_active,
  input logic       irq_take,
  input logic [3:0] irq_vector
);
  // ************
  // Properties
  // ************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_sleep;
    !low_osc_run |-> !cpu_run && !instr_tick && !timer_zero_active && !second_timer_active && !usb_active;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep gating");
  property p_green; !cpu_run && low_osc_run |-> !second_timer_active && !usb_active && !instr_tick; endproperty
  a_green: assert property (p_green) else $error("green gating");
  property p_usb_slow; sys_clk_low |-> !usb_active; endproperty
  a_usb_slow: assert property (p_usb_slow) else $error("usb in slow");
  property p_normal_osc; cpu_run && !sys_clk_low |-> high_osc_run && low_osc_run; endproperty
  a_normal_osc: assert property (p_normal_osc) else $error("normal osc");
  property p_tick; cpu_run && !sys_clk_low && $past(rst_n) |-> instr_tick; endproperty
  a_tick: assert property (p_tick) else $error("normal tick");
  property p_take; irq_take |-> irq_vector == 4'h8 ##1 !irq_take; endproperty
  a_take: assert property (p_take) else $error("take");
  property p_wake; $rose(low_osc_run) |-> cpu_run && !sys_clk_low && high_osc_run; endproperty
  a_wake: assert property (p_wake) else $error("wake mode");
endmodule

bind power_mode_wakeup_irq_ctrl pwr_checker pwr_checker_inst (.clk(clk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .high_osc_run(high_osc_run),
  .low_osc_run(low_osc_run), .sys_clk_low(sys_clk_low), .cpu_run(cpu_run), .instr_tick(instr_tick),
  .timer_zero_active(timer_zero_active), .second_timer_active(second_timer_active),
  .usb_active(usb_active), .irq_take(irq_take), .irq_vector(irq_vector));

/* File: tb/core_model.sv */
// Core and low oscillator model on the far side of the controller.
// Assumes the controller clock and reset.
`timescale 1ns/100ps
module core_model (
  // Clock and reset
  input  logic clk,
  input  logic rst_n,
  // From controller
  input  logic irq_take,
  input  logic low_osc_run,
  input  logic quick,
  // To controller
  output logic return_from_interrupt,
  output logic low_osc_clk
);
  logic [1:0] div;
  int         wait_n;
  // ************
  // Behaviour
  // ************
  // Low clock toggles only while enabled and stands still otherwise
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div <= 2'h0;
      low_osc_clk <= 1'b0;
    end else if (low_osc_run) begin
      div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
      if (div == 2'h2) low_osc_clk <= ~low_osc_clk;
    end
  end
  // Service routine ends promptly or after a long delay
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_n <= 0;
      return_from_interrupt <= 1'b0;
    end else begin
      return_from_interrupt <= (wait_n == 1);
      if (irq_take) wait_n <= quick ? 1 : 30;
      else if (wait_n != 0) wait_n <= wait_n - 1;
    end
  end
endmodule

/* File: tb/test_power_mode_wakeup_irq_ctrl.sv */
// Self-checking bench for the power mode, wakeup and interrupt controller.
// Assumes the core model and the bound port checker.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module test_power_mode_wakeup_irq_ctrl;
  logic        clk, rst_n, cyc, stb, we, tgl, quick, lp;
  logic [11:0] adr;
  logic [31:0] dat, e;
  logic [15:0] pins;
  logic [3:0]  evs, vec;
  logic [7:0]  v;
  logic [31:0] q[$];
  wire  [31:0] dout;
  wire         ack, ret, lclk, hrun, lrun, slow, run, tick, t0a, tc0a, usba, take;
  int          n_fail, checks, n, i, nt, nr;

  power_mode_wakeup_irq_ctrl #(.PORT_W(16), .WAKE_CYCLES(20), .STARTUP_CYCLES(2)) power_mode_wakeup_irq_ctrl_inst (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack), .port_pins(pins), .usb_bus_toggle(tgl), .low_osc_clk(lclk),
    .timer_zero_overflow(evs[0]), .second_timer_overflow(evs[1]), .serial_done(evs[2]), .usb_done(evs[3]),
    .return_from_interrupt(ret), .high_osc_run(hrun), .low_osc_run(lrun), .sys_clk_low(slow), .cpu_run(run),
    .instr_tick(tick), .timer_zero_active(t0a), .second_timer_active(tc0a), .usb_active(usba),
    .irq_take(take), .irq_vector(vec));
  core_model core_model_inst (.clk(clk), .rst_n(rst_n), .irq_take(take), .low_osc_run(lrun), .quick(quick),
    .return_from_interrupt(ret), .low_osc_clk(lclk));

  // ************
  // Tasks
  // ************
  task summarize;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d};
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
    cyc <= 1'b0; stb <= 1'b0;
    if (n >= 50) begin n_fail++; $display("BAD ack exp 1 got 0"); summarize(); end
  endtask
  task rd(input logic [11:0] a, input logic [7:0] x); q.push_back({24'h0, x}); bus(1'b0, a, 8'h00); endtask
  task ev(input int k); @(posedge clk); evs <= 4'h1 << k; @(posedge clk); evs <= 4'h0; endtask
  task settle(input int k); repeat (k) @(posedge clk); #2; endtask
  task wait_run(input int lim);
    n = 0;
    while (run !== 1'b1 && n < lim) begin @(posedge clk); n++; end
    if (n >= lim) begin n_fail++; $display("BAD cpu_run exp 1 got 0"); summarize(); end
    #2;
  endtask

  // Read results are compared in the order they were noted
  always @(posedge clk)
    if (ack === 1'b1 && cyc && !we) begin
      if (q.size() == 0) begin n_fail++; $display("BAD read exp none got %0h", dout); end
      else begin e = q.pop_front(); `CHK("read", e, dout) end
    end

  initial begin clk = 1'b0; forever #12.5 clk = ~clk; end
  initial begin #1000000; n_fail++; summarize(); end

  initial begin
    rst_n = 0; cyc = 0; stb = 0; we = 0; adr = 0; dat = 0; pins = 0; tgl = 0; evs = 0; quick = 0;
    n_fail = 0; checks = 0;
    void'($urandom(73));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(12'h320, 8'h00); rd(12'h324, 8'h00); rd(12'h328, 8'h00);
    rd(12'h37C, 8'h07); rd(12'h380, 8'h00); rd(12'h384, 8'h1C);
    rd(12'h3FC, 8'h00); rd(12'h321, 8'h00);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin v = $urandom; bus(1, 12'h324, v); rd(12'h324, {1'b0, v[6:0]}); end
    bus(1, 12'h324, 8'h40); bus(1, 12'h37C, 8'h87); ev(3);
    n = 0;
    while (take !== 1'b1 && n < 10) begin @(posedge clk); n++; end
    `CHK("irq_take", 1'b1, take)
    `CHK("irq_vector", 4'h8, vec)
    rd(12'h37C, 8'h00); rd(12'h320, 8'h40); bus(1, 12'h320, 8'h00);
    settle(40); rd(12'h37C, 8'h87); rd(12'h320, 8'h00);
    quick <= 1'b1; bus(1, 12'h324, 8'h08); ev(2); settle(10); bus(1, 12'h324, 8'h00);
    rd(12'h320, 8'h08); bus(1, 12'h320, 8'h00); bus(1, 12'h37C, 8'h07);
    $display("test irq done");
    bus(1, 12'h380, 8'h07); settle(3);
    `CHK("t0a", 1'b1, t0a) `CHK("tc0a", 1'b1, tc0a) `CHK("usba", 1'b1, usba)
    bus(1, 12'h328, 8'h04); settle(3);
    `CHK("slow", 1'b1, slow) `CHK("usba", 1'b0, usba) `CHK("tc0a", 1'b1, tc0a)
    bus(1, 12'h328, 8'h06); settle(60);
    `CHK("hrun", 1'b0, hrun) `CHK("lrun", 1'b1, lrun)
    nt = 0; nr = 0; lp = lclk;
    repeat (480) begin @(posedge clk); nt += tick; nr += (lclk && !lp); lp = lclk; end
    `CHK("tick", 1'b1, (nr > 40) && (nt * 4 >= nr - 4) && (nt * 4 <= nr + 4))
    bus(1, 12'h380, 8'h06); bus(1, 12'h328, 8'h16); settle(3);
    `CHK("run", 1'b0, run) `CHK("tc0a", 1'b0, tc0a)
    ev(3); ev(0); settle(5); `CHK("run", 1'b0, run)
    bus(1, 12'h380, 8'h07); settle(2); `CHK("t0a", 1'b1, t0a)
    ev(0); wait_run(4); `CHK("slow", 1'b1, slow)
    rd(12'h328, 8'h06); rd(12'h320, 8'h10); bus(1, 12'h320, 8'h00);
    bus(1, 12'h328, 8'h04); settle(40); `CHK("hrun", 1'b1, hrun)
    bus(1, 12'h328, 8'h00); settle(3); `CHK("slow", 1'b0, slow) `CHK("tick", 1'b1, tick)
    $display("test modes done");
    for (i = 0; i < 2; i++) begin
      bus(1, 12'h328, 8'h0C); settle(3); `CHK("lrun", 1'b0, lrun)
      ev(0); settle(4); `CHK("run", 1'b0, run)
      @(posedge clk);
      if (i == 1) tgl <= ~tgl;
      else pins[0] <= ~pins[0];
      settle(23); `CHK("run", 1'b0, run)
      wait_run(20); `CHK("slow", 1'b0, slow)
      rd(12'h328, 8'h00);
    end
    $display("test sleep done");
    bus(1, 12'h328, 8'h18); settle(3); `CHK("run", 1'b1, run) `CHK("lrun", 1'b1, lrun)
    bus(1, 12'h328, 8'h00);
    @(posedge clk); pins[1:0] <= 2'h2; ev(1); settle(6);
    rd(12'h320, 8'h27); bus(1, 12'h320, 8'h00); rd(12'h320, 8'h00);
    $display("test flags done");
    settle(4);
    summarize();
  end
endmodule
